// File: common/pbh_defs.svh
// Constants for the primary bus hold and release logic
`ifndef PBH_DEFS_SVH
`define PBH_DEFS_SVH
`define PBH_PH_DIV 4'h2
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`endif

// File: common/pbh_pkg.sv
// Types for the primary bus hold and release logic
package pbh_pkg;
    typedef enum logic [2:0] {
        PBH_RUN, PBH_QUIET, PBH_FLOAT, PBH_HELD, PBH_LINGER, PBH_RESTORE
    } pbh_state_t;
endpackage

// File: common/pbh_phase_if.sv
// Phase-one clock edge strobes shared between modules
`timescale 1ns/1ps
`default_nettype none
interface pbh_phase_if;
    logic phase_one_clock;
    logic fall;
    logic rise;
    modport gen (output phase_one_clock, output fall, output rise);
    modport use_ (input phase_one_clock, input fall, input rise);
endinterface
`default_nettype wire

// File: rtl/pbh_phase_gen.sv
// Phase-one clock divider with edge strobes
`timescale 1ns/1ps
`default_nettype none
`include "pbh_defs.svh"
module pbh_phase_gen (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    pbh_phase_if.gen ph // Phase strobes
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic lvl;
    logic next_lvl;
    // Half period counter, toggle level at each wrap
    always_comb begin
        next_cnt = cnt + 4'h1;
        next_lvl = lvl;
        if (cnt == `PBH_PH_DIV - 4'h1) begin
            next_cnt = 4'h0;
            next_lvl = ~lvl;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 4'h0;
            lvl <= 1'b0;
        end else begin
            cnt <= next_cnt;
            lvl <= next_lvl;
        end
    end
    // Strobes mark the last cycle before the level changes
    assign ph.phase_one_clock = lvl;
    assign ph.fall = lvl && (cnt == `PBH_PH_DIV - 4'h1);
    assign ph.rise = !lvl && (cnt == `PBH_PH_DIV - 4'h1);
endmodule
`default_nettype wire

// File: rtl/pbh_hold_ctrl.sv
// Primary bus hold handshake and bus float control
`timescale 1ns/1ps
`default_nettype none
`include "pbh_defs.svh"
module pbh_hold_ctrl (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic hold_req_n, // Async hold request pin
    input wire logic hold_override, // Control bit, refuses hold
    input wire logic core_req, // Core bus request
    input wire logic core_wr, // Request is a write
    input wire logic [`PBH_ADDR_W-1:0] core_addr, // Core address
    input wire logic [`PBH_DATA_W-1:0] core_wdata, // Core write data
    output logic core_stall, // Core must wait
    output logic phase_one_clock, // Phase-one clock out
    output logic bus_hold_grant_n, // Hold acknowledge, active low
    output logic bus_strobe_n, // Strobe out, active low
    output logic bus_strobe_oe_n, // Strobe enable, low drives
    output logic bus_rw, // Read high, write low
    output logic bus_rw_oe_n, // Read/write enable, low drives
    output logic [`PBH_ADDR_W-1:0] bus_addr, // Address out
    output logic bus_addr_oe_n, // Address enable, low drives
    output logic [`PBH_DATA_W-1:0] bus_data, // Data out
    output logic bus_data_oe_n // Data enable, low drives
);
    import pbh_pkg::*;
    pbh_phase_if ph ();
    pbh_phase_gen u_phase (
        .clk(clk),
        .srst(srst),
        .ph(ph)
    );
    assign phase_one_clock = ph.phase_one_clock;

    // Two stage synchroniser; only stage two is read
    logic req_meta;
    logic req_sync;
    always_ff @(posedge clk) begin
        if (srst) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
        end else begin
            req_meta <= ~hold_req_n;
            req_sync <= req_meta;
        end
    end

    // Override beats the request, late set-up costs one phase edge
    logic want_hold;
    assign want_hold = req_sync && !hold_override;

    pbh_state_t state;
    pbh_state_t next_state;
    logic grant_n;
    logic next_grant_n;
    logic strobe_n;
    logic next_strobe_n;
    logic ctl_oe_n;
    logic next_ctl_oe_n;
    logic addr_oe_n;
    logic next_addr_oe_n;
    logic data_oe_n;
    logic next_data_oe_n;
    logic posted;
    logic next_posted;
    logic [`PBH_ADDR_W-1:0] post_addr;
    logic [`PBH_ADDR_W-1:0] next_post_addr;
    logic [`PBH_DATA_W-1:0] post_data;
    logic [`PBH_DATA_W-1:0] next_post_data;
    logic xfer_rw;
    logic next_xfer_rw;
    logic [`PBH_ADDR_W-1:0] xfer_addr;
    logic [`PBH_ADDR_W-1:0] next_xfer_addr;
    logic [`PBH_DATA_W-1:0] xfer_data;
    logic [`PBH_DATA_W-1:0] next_xfer_data;

    logic bus_free;
    assign bus_free = (state == PBH_RUN);

    // Hold sequencer, every pin change lands on a phase edge
    always_comb begin
        next_state = state;
        next_grant_n = grant_n;
        next_ctl_oe_n = ctl_oe_n;
        next_addr_oe_n = addr_oe_n;
        next_data_oe_n = data_oe_n;
        unique case (state)
            PBH_RUN: begin
                // Strobe is forced high by the core block at this same edge
                if (want_hold && ph.fall) begin
                    next_state = PBH_QUIET;
                end
            end
            PBH_QUIET: begin
                // Strobe already high; float control and address drivers on next fall
                if (hold_override) begin
                    next_state = PBH_RESTORE;
                end else if (ph.fall) begin
                    next_ctl_oe_n = 1'b1;
                    next_addr_oe_n = 1'b1;
                    next_grant_n = 1'b0;
                    next_state = PBH_FLOAT;
                end
            end
            PBH_FLOAT: begin
                if (ph.rise) begin
                    next_data_oe_n = 1'b1;
                    next_state = PBH_HELD;
                end
            end
            PBH_HELD: begin
                // Grant held one full period past request release
                if (ph.fall && (hold_override || !req_sync)) begin
                    next_state = hold_override ? PBH_RESTORE : PBH_LINGER;
                end
            end
            PBH_LINGER: begin
                // One full period of grant after the release was seen, then hand back
                if (ph.fall) begin
                    next_grant_n = 1'b1;
                    next_addr_oe_n = 1'b0;
                    next_ctl_oe_n = 1'b0;
                    next_data_oe_n = 1'b0;
                    next_state = PBH_RUN;
                end
            end
            PBH_RESTORE: begin
                if (ph.fall) begin
                    next_grant_n = 1'b1;
                    next_addr_oe_n = 1'b0;
                    next_ctl_oe_n = 1'b0;
                    next_data_oe_n = 1'b0;
                    next_state = PBH_RUN;
                end
            end
        endcase
    end
    // Sequencer registers; reset leaves every driver enabled
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= PBH_RUN;
            grant_n <= 1'b1;
            ctl_oe_n <= 1'b0;
            addr_oe_n <= 1'b0;
            data_oe_n <= 1'b0;
        end else begin
            state <= next_state;
            grant_n <= next_grant_n;
            ctl_oe_n <= next_ctl_oe_n;
            addr_oe_n <= next_addr_oe_n;
            data_oe_n <= next_data_oe_n;
        end
    end

    // Core side: one posted write during hold, then stall
    logic take_now;
    logic take_post;
    always_comb begin
        // A pending hold blocks new transfers, so none is lost at the handover
        take_now = core_req && bus_free && !posted && !want_hold;
        take_post = core_req && !bus_free && core_wr && !posted;
        core_stall = core_req && !take_now && !take_post;
        next_posted = posted;
        next_post_addr = post_addr;
        next_post_data = post_data;
        next_xfer_rw = xfer_rw;
        next_xfer_addr = xfer_addr;
        next_xfer_data = xfer_data;
        // Strobe idles high, so entering hold always finds it inactive
        next_strobe_n = 1'b1;
        if (take_post) begin
            next_posted = 1'b1;
            next_post_addr = core_addr;
            next_post_data = core_wdata;
        end
        // Drain the posted write first once the bus is back
        if (bus_free && posted && !want_hold) begin
            next_posted = 1'b0;
            next_xfer_rw = 1'b0;
            next_xfer_addr = post_addr;
            next_xfer_data = post_data;
            next_strobe_n = 1'b0;
        end else if (take_now) begin
            next_xfer_rw = !core_wr;
            next_xfer_addr = core_addr;
            next_xfer_data = core_wdata;
            next_strobe_n = 1'b0;
        end
    end
    // Transfer registers; strobe low lasts one clock per transfer
    always_ff @(posedge clk) begin
        if (srst) begin
            strobe_n <= 1'b1;
            posted <= 1'b0;
            post_addr <= '0;
            post_data <= '0;
            xfer_rw <= 1'b1;
            xfer_addr <= '0;
            xfer_data <= '0;
        end else begin
            strobe_n <= next_strobe_n;
            posted <= next_posted;
            post_addr <= next_post_addr;
            post_data <= next_post_data;
            xfer_rw <= next_xfer_rw;
            xfer_addr <= next_xfer_addr;
            xfer_data <= next_xfer_data;
        end
    end

    // Pins come straight from registers, so they never glitch
    assign bus_hold_grant_n = grant_n;
    assign bus_strobe_n = strobe_n;
    assign bus_strobe_oe_n = ctl_oe_n;
    assign bus_rw = xfer_rw;
    assign bus_rw_oe_n = ctl_oe_n;
    assign bus_addr = xfer_addr;
    assign bus_addr_oe_n = addr_oe_n;
    assign bus_data = xfer_data;
    assign bus_data_oe_n = data_oe_n;
endmodule
`default_nettype wire

// File: verif/pbh_master_model.sv
// External bus master model that asks for the bus
`timescale 1ns/1ps
`default_nettype none
module pbh_master_model (
    input wire logic clk, // System clock
    input wire logic start, // Begin one request
    input wire logic [7:0] len, // Low time in clk
    output logic hold_req_n // Hold request, active low
);
    logic [7:0] left = 8'h00;
    // Clamped to two phase periods, never shorter
    always @(negedge clk) begin
        if (start) begin
            left <= (len < 8'd8) ? 8'd8 : len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign hold_req_n = (left == 8'h00);
endmodule
`default_nettype wire

// File: verif/pbh_hold_ctrl_assertions.sv
// Checker for hold handshake and bus float order
`timescale 1ns/1ps
`default_nettype none
module pbh_hold_ctrl_assertions (
    input wire logic clk, // System clock
    input wire logic srst, // Sync reset
    input wire logic hold_req_n, // Request pin
    input wire logic hold_override, // Override bit
    input wire logic phase_one_clock, // Phase clock
    input wire logic bus_hold_grant_n, // Grant
    input wire logic bus_strobe_n, // Strobe
    input wire logic bus_strobe_oe_n, // Strobe enable
    input wire logic bus_rw_oe_n, // R/W enable
    input wire logic bus_addr_oe_n, // Address enable
    input wire logic bus_data_oe_n // Data enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Grant may only move while the phase clock is low
    chk_grant_on_fall: assert property ($changed(bus_hold_grant_n) |-> !phase_one_clock)
        else $error("grant moved off phase fall");
    chk_grant_min_low: assert property ($fell(bus_hold_grant_n) |-> !bus_hold_grant_n [*4])
        else $error("grant low too short");
    chk_req_to_grant: assert property ($fell(hold_req_n) && !hold_override |-> ##[3:14] !bus_hold_grant_n)
        else $error("grant missing after request");
    chk_grant_release: assert property ($rose(hold_req_n) && !bus_hold_grant_n
        |-> !bus_hold_grant_n [*6] ##[1:12] bus_hold_grant_n)
        else $error("grant release timing");
    chk_override_refuse: assert property (hold_override ##1 (hold_override && bus_hold_grant_n)
        |=> bus_hold_grant_n)
        else $error("hold granted under override");
    chk_override_exit: assert property ($rose(hold_override) && !bus_hold_grant_n |-> ##[1:10] bus_hold_grant_n)
        else $error("override did not end hold");
    chk_strobe_high_first: assert property ($rose(bus_strobe_oe_n) |-> bus_strobe_n && $past(bus_strobe_n, 4))
        else $error("strobe not high before float");
    chk_ctl_float_grant: assert property ($rose(bus_addr_oe_n)
        |-> $fell(bus_hold_grant_n) && bus_strobe_oe_n && bus_rw_oe_n)
        else $error("control float not with grant");
    chk_data_float_rise: assert property ($rose(bus_data_oe_n) |-> phase_one_clock && bus_addr_oe_n)
        else $error("data float off phase rise");
    chk_restore_order: assert property ($fell(bus_addr_oe_n)
        |-> !bus_strobe_oe_n && !bus_rw_oe_n && bus_hold_grant_n && !phase_one_clock)
        else $error("restore order wrong");
    chk_no_access_hold: assert property (!bus_hold_grant_n || bus_strobe_oe_n |-> bus_strobe_n)
        else $error("strobe during hold");
    // Main scenarios reached
    cov_grant: cover property ($fell(bus_hold_grant_n));
    cov_override_exit: cover property ($rose(hold_override) && !bus_hold_grant_n);
    cov_restore: cover property ($fell(bus_addr_oe_n));
endmodule
bind pbh_hold_ctrl pbh_hold_ctrl_assertions u_chk (.clk, .srst, .hold_req_n, .hold_override, .phase_one_clock,
    .bus_hold_grant_n, .bus_strobe_n, .bus_strobe_oe_n, .bus_rw_oe_n, .bus_addr_oe_n, .bus_data_oe_n);
`default_nettype wire

// File: verif/pbh_hold_ctrl_tb.sv
// Self-checking bench for the bus hold handshake
`timescale 1ns/1ps
`default_nettype none
module pbh_hold_ctrl_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [7:0] len = 8'h00;
    logic hold_req_n, hold_override, core_req, core_wr, core_stall, phase_one_clock, bus_hold_grant_n;
    logic bus_strobe_n, bus_strobe_oe_n, bus_rw, bus_rw_oe_n, bus_addr_oe_n, bus_data_oe_n;
    logic [23:0] core_addr, bus_addr;
    logic [31:0] core_wdata, bus_data;
    int err_count = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    pbh_hold_ctrl uut (.clk, .srst, .hold_req_n, .hold_override, .core_req, .core_wr, .core_addr, .core_wdata,
        .core_stall, .phase_one_clock, .bus_hold_grant_n, .bus_strobe_n, .bus_strobe_oe_n, .bus_rw, .bus_rw_oe_n,
        .bus_addr, .bus_addr_oe_n, .bus_data, .bus_data_oe_n);
    pbh_master_model master (.clk, .start, .len, .hold_req_n);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic drive(input logic r, input logic w, input logic [23:0] a, input logic [31:0] d);
        core_req = r;
        core_wr = w;
        core_addr = a;
        core_wdata = d;
    endtask
    // Nonblocking so the model sees the pulse one edge later
    task automatic request(input logic [7:0] n);
        start <= 1'b1;
        len <= n;
        @(negedge clk);
        start <= 1'b0;
    endtask
    task automatic wait_grant(input logic v);
        int n;
        n = 0;
        while (bus_hold_grant_n !== v && n < 60) begin
            @(negedge clk);
            n++;
        end
        check("grant", {31'h0, bus_hold_grant_n}, {31'h0, v});
    endtask
    task automatic t_access;
        drive(1'b1, 1'b1, 24'h00a5c3, 32'h1234_5678);
        #1 check("run take", {31'h0, core_stall}, 32'h0);
        @(negedge clk);
        drive(1'b1, 1'b0, 24'h000010, 32'h0);
        check("wr", {bus_strobe_n, bus_rw, 6'h0, bus_addr}, 32'h00a5c3);
        check("wdata", bus_data, 32'h1234_5678);
        @(negedge clk);
        drive(1'b0, 1'b0, 24'h0, 32'h0);
        check("rd", {bus_strobe_n, bus_rw, 6'h0, bus_addr}, 32'h4000_0010);
        $display("t_access done");
    endtask
    // Read stalls in hold, first write posts, second stalls
    task automatic t_hold;
        int n;
        n = 0;
        request(8'd40);
        wait_grant(1'b0);
        repeat (3) @(negedge clk);
        check("float", {bus_strobe_oe_n, bus_rw_oe_n, bus_addr_oe_n, bus_data_oe_n}, 32'hf);
        drive(1'b1, 1'b0, 24'h000020, 32'h0);
        #1 check("rd stall", {31'h0, core_stall}, 32'h1);
        @(negedge clk);
        drive(1'b1, 1'b1, 24'h000030, 32'hcafe_0001);
        #1 check("post", {31'h0, core_stall}, 32'h0);
        @(negedge clk);
        drive(1'b1, 1'b1, 24'h000040, 32'hcafe_0002);
        #1 check("wr stall", {31'h0, core_stall}, 32'h1);
        @(negedge clk);
        drive(1'b0, 1'b0, 24'h0, 32'h0);
        wait_grant(1'b1);
        while (bus_strobe_n !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("posted", {bus_strobe_n, bus_rw, 6'h0, bus_addr}, 32'h30);
        check("pdata", bus_data, 32'hcafe_0001);
        $display("t_hold done");
    endtask
    task automatic t_override;
        hold_override = 1'b1;
        request(8'd30);
        repeat (25) @(negedge clk);
        check("refused", {31'h0, bus_hold_grant_n}, 32'h1);
        repeat (10) @(negedge clk);
        hold_override = 1'b0;
        request(8'd80);
        wait_grant(1'b0);
        hold_override = 1'b1;
        repeat (12) @(negedge clk);
        check("ended", {bus_hold_grant_n, bus_addr_oe_n, bus_strobe_oe_n}, 32'h4);
        hold_override = 1'b0;
        repeat (80) @(negedge clk);
        wait_grant(1'b1);
        $display("t_override done");
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #20000;
        err_count++;
        end_sim();
    end
    initial begin
        hold_override = 1'b0;
        drive(1'b0, 1'b0, 24'h0, 32'h0);
        repeat (6) @(negedge clk);
        check("reset", {phase_one_clock, bus_hold_grant_n, bus_strobe_n, bus_strobe_oe_n, bus_rw_oe_n,
            bus_addr_oe_n, bus_data_oe_n}, 32'h30);
        srst = 1'b0;
        @(negedge clk);
        t_access();
        t_hold();
        t_override();
        end_sim();
    end
endmodule
`default_nettype wire
